// ---- output_terminal_function_select.sv ----
// Operation
// - mode 0 pulse train, 1 switch; reset 1
// - pulse train up to 50 kHz
// - nine selectors with fixed reset codes
// - code 0 keeps output inactive
// - code 1 means ready, no fault
// - code 2 means running, even zero
// - code 3 means stopped by fault
// - code 5 means frequency limited
// - code 6 means torque limited, stalled
// - code 7 means upper limit reached
// - code 8 lower limit, off at stop
// - code 9 lower limit, on at stop
// - code 10 means reverse running
// - code 11 zero speed, off at stop
// - code 12 zero speed, on at stop
// - code 13 set count reached
// - code 14 designated count reached
// - code 15 length target exceeded
// - code 16 one 250 ms pulse
`timescale 1ns/10ps
`default_nettype none

module output_terminal_function_select
    import terminal_select_pkg::*;
#(
    parameter int seq_pulse_len = seq_pulse_cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire terminal_select_pkg::drive_status_s status_in,
    output terminal_select_pkg::terminals_s terminals
);
    import terminal_select_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic [15:0] mux_mode;
        logic [num_outputs-1:0][15:0] func;
        logic [15:0] pulse_div;
        logic [15:0] pulse_cnt;
        logic pulse_level;
        logic [31:0] seq_cnt;
        logic seq_active;
        logic seq_prev;
        logic [num_outputs-1:0] selected;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        terminals_s terminals;
    } state_s;

    state_s state;
    state_s next_state;
    drive_status_s stat_meta;
    drive_status_s stat;

    // status arrives from the drive core's own clock tree, so resync it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_meta <= '0;
            stat <= '0;
        end else begin
            stat_meta <= status_in;
            stat <= stat_meta;
        end
    end

    function automatic logic pick(input logic [15:0] code, input drive_status_s s,
                                  input logic seq_pulse);
        logic stopped;
        stopped = !s.running;
        case (code)
            fn_none: pick = 1'b0;
            fn_ready: pick = s.ready && !s.fault_stop;
            fn_running: pick = s.running;
            fn_fault_stop: pick = s.fault_stop;
            fn_fault_coast: pick = s.fault_coast && !s.undervoltage;
            fn_freq_limited: pick = s.freq_limited;
            fn_torque_limited: pick = s.torque_limited;
            fn_upper_reached: pick = s.upper_reached;
            fn_lower_run: pick = s.lower_reached && !stopped;
            fn_lower_stop: pick = s.lower_reached || stopped;
            fn_reverse: pick = s.reverse && s.running;
            fn_zero_run: pick = s.zero_freq && !stopped;
            fn_zero_stop: pick = s.zero_freq || stopped;
            fn_set_count: pick = s.set_count_reached;
            fn_designated_count: pick = s.designated_count_reached;
            fn_length: pick = s.length_reached;
            fn_sequencer_done: pick = seq_pulse;
            fn_fdt_first: pick = s.freq_level_detect_first;
            fn_fdt_second: pick = s.freq_level_detect_second;
            fn_freq_reached: pick = s.freq_reached;
            default: pick = 1'b0;
        endcase
    endfunction

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        logic [11:0] idx;
        logic setup;
        logic access;
        idx = '0;
        next_state = state;
        setup = psel && !penable;
        access = psel && penable;
        next_state.pready = setup;
        next_state.pslverr = 1'b0;

        // a retrigger restarts the full width instead of stretching it
        // 250 ms pulse per cycle
        next_state.seq_prev = stat.sequencer_cycle_done;
        if (stat.sequencer_cycle_done && !state.seq_prev) begin
            next_state.seq_active = 1'b1;
            next_state.seq_cnt = 32'(seq_pulse_len - 1);
        end else if (state.seq_active) begin
            if (state.seq_cnt == '0) begin
                next_state.seq_active = 1'b0;
            end else begin
                next_state.seq_cnt = state.seq_cnt - 32'd1;
            end
        end

        // counter runs in both modes, so a mode change needs no restart
        // half period never below 50 kHz limit
        if (state.pulse_cnt == '0) begin
            next_state.pulse_cnt = state.pulse_div - 16'd1;
            next_state.pulse_level = !state.pulse_level;
        end else begin
            next_state.pulse_cnt = state.pulse_cnt - 16'd1;
        end

        for (int i = 0; i < num_outputs; i++) begin
            next_state.selected[i] = pick(state.func[i], stat, state.seq_active);
        end

        next_state.terminals.multiplexed_pulse_output =
            (state.mux_mode == mux_mode_pulse) && state.pulse_level;
        next_state.terminals.multiplexed_switch_output =
            (state.mux_mode == mux_mode_switch) && state.selected[0];
        next_state.terminals.board_relay_contacts = state.selected[1];
        next_state.terminals.base_collector_output = state.selected[2];
        next_state.terminals.extension_outputs = state.selected[7:3];
        next_state.terminals.extension_relay_contacts = state.selected[8];

        // ***************************************************
        // apb slave
        // ***************************************************
        if (setup) begin
            next_state.prdata = '0;
            idx = (paddr - addr_func_base) >> 2;
            if (paddr[1:0] != 2'b00) begin
                next_state.pslverr = 1'b1;
            end else if (paddr == addr_mux_mode) begin
                next_state.prdata = {16'h0000, state.mux_mode};
            end else if (paddr >= addr_func_base && paddr < addr_status) begin
                next_state.prdata = {16'h0000, state.func[idx[3:0]]};
            end else if (paddr == addr_status) begin
                next_state.prdata = 32'(stat);
            end else if (paddr == addr_terminals) begin
                next_state.prdata = 32'(state.terminals);
            end else if (paddr == addr_pulse_div) begin
                next_state.prdata = {16'h0000, state.pulse_div};
            end else begin
                next_state.pslverr = 1'b1;
            end
        end
        if (access && state.pready && pwrite && !state.pslverr) begin
            idx = (paddr - addr_func_base) >> 2;
            if (paddr == addr_mux_mode) begin
                next_state.mux_mode = pwdata[15:0];
            end else if (paddr >= addr_func_base && paddr < addr_status) begin
                next_state.func[idx[3:0]] = pwdata[15:0];
            end else if (paddr == addr_pulse_div) begin
                if (pwdata[15:0] < 16'(pulse_min_half)) begin
                    next_state.pulse_div = 16'(pulse_min_half);
                end else begin
                    next_state.pulse_div = pwdata[15:0];
                end
            end
        end
        if (access && state.pready) begin
            next_state.pready = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.mux_mode <= mux_mode_reset;
            for (int i = 0; i < num_outputs; i++) begin
                state.func[i] <= func_reset[i];
            end
            state.pulse_div <= pulse_div_reset;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign terminals = state.terminals;

    // ***************************************************
    // checks
    // ***************************************************
    a_zero_inactive: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_none) |=> !state.selected[1])
        else $error("relay active with code 0");
    a_pulse_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (state.mux_mode == mux_mode_pulse) |=> !terminals.multiplexed_switch_output)
        else $error("switch output active in pulse mode");
    a_pulse_floor: assert property (@(posedge pclk) disable iff (!presetn)
        state.pulse_div >= 16'(pulse_min_half))
        else $error("pulse half period too short");
    a_running_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[2] == fn_running) && $stable(state.func[2])
        |=> state.selected[2] == $past(stat.running))
        else $error("running code not followed");
    a_lower_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_lower_stop) && !stat.running |=> state.selected[0])
        else $error("code 9 inactive at stop");
    a_zero_run: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_zero_run) && !stat.running |=> !state.selected[0])
        else $error("code 11 active at stop");
    a_seq_start: assert property (@(posedge pclk) disable iff (!presetn)
        stat.sequencer_cycle_done && !state.seq_prev |=> state.seq_active)
        else $error("sequencer pulse not started");
    a_unknown_code: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[3] > fn_freq_reached) |=> !state.selected[3])
        else $error("unknown code drives output");

    // ***************************************************
    // selector checks
    // ***************************************************
    a_ready_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[2] == fn_ready) && stat.ready && !stat.fault_stop |=> state.selected[2])
        else $error("code 1 inactive when ready");
    a_ready_fault: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[2] == fn_ready) && stat.fault_stop |=> !state.selected[2])
        else $error("code 1 active on fault");
    a_fault_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_fault_stop) |=> state.selected[0] == $past(stat.fault_stop))
        else $error("code 3 not followed");
    a_coast_low: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_fault_coast) && stat.undervoltage |=> !state.selected[0])
        else $error("code 4 active at undervoltage");
    a_coast_set: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_fault_coast) && stat.fault_coast && !stat.undervoltage
        |=> state.selected[0])
        else $error("code 4 inactive after coast fault");
    a_freq_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_freq_limited) |=> state.selected[1] == $past(stat.freq_limited))
        else $error("code 5 not followed");
    a_torque_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_torque_limited)
        |=> state.selected[1] == $past(stat.torque_limited))
        else $error("code 6 not followed");
    a_upper_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_upper_reached)
        |=> state.selected[1] == $past(stat.upper_reached))
        else $error("code 7 not followed");
    a_lower_run: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_lower_run) && !stat.running |=> !state.selected[0])
        else $error("code 8 active at stop");
    a_reverse_run: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_reverse) && stat.reverse && stat.running |=> state.selected[1])
        else $error("code 10 inactive in reverse");
    a_zero_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[0] == fn_zero_stop) && stat.zero_freq |=> state.selected[0])
        else $error("code 12 inactive at zero speed");
    a_set_count: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_set_count)
        |=> state.selected[1] == $past(stat.set_count_reached))
        else $error("code 13 not followed");
    a_designated_count: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_designated_count)
        |=> state.selected[1] == $past(stat.designated_count_reached))
        else $error("code 14 not followed");
    a_length_target: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_length)
        |=> state.selected[1] == $past(stat.length_reached))
        else $error("code 15 not followed");
    a_detect_first: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_fdt_first)
        |=> state.selected[1] == $past(stat.freq_level_detect_first))
        else $error("code 17 not followed");
    a_freq_reached: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_freq_reached)
        |=> state.selected[1] == $past(stat.freq_reached))
        else $error("code 19 not followed");

    // ***************************************************
    // terminal checks
    // ***************************************************
    a_switch_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (state.mux_mode == mux_mode_switch)
        |=> terminals.multiplexed_switch_output == $past(state.selected[0]))
        else $error("switch output not following selector");
    a_pulse_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (state.mux_mode != mux_mode_pulse) |=> !terminals.multiplexed_pulse_output)
        else $error("pulse output active in switch mode");
    a_relay_running: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[1] == fn_running)
        |-> ##2 terminals.board_relay_contacts == $past(stat.running, 2))
        else $error("relay not following running");
    a_ext_relay: assert property (@(posedge pclk) disable iff (!presetn)
        (state.func[8] == fn_none) |-> ##2 !terminals.extension_relay_contacts)
        else $error("extension relay active with code 0");

    // ***************************************************
    // sequencer and pulse checks
    // ***************************************************
    a_seq_reload: assert property (@(posedge pclk) disable iff (!presetn)
        stat.sequencer_cycle_done && !state.seq_prev
        |=> state.seq_cnt == 32'(seq_pulse_len - 1))
        else $error("sequencer pulse width not reloaded");
    a_seq_expire: assert property (@(posedge pclk) disable iff (!presetn)
        state.seq_active && (state.seq_cnt == '0)
        && !(stat.sequencer_cycle_done && !state.seq_prev) |=> !state.seq_active)
        else $error("sequencer pulse too long");
    a_pulse_rate: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(state.pulse_level) |-> $past(state.pulse_cnt) == '0)
        else $error("pulse toggled before half period");

    // ***************************************************
    // register checks
    // ***************************************************
    a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
        state.pready |=> !state.pready)
        else $error("pready held too long");
    a_error_ready: assert property (@(posedge pclk) disable iff (!presetn)
        state.pslverr |-> state.pready)
        else $error("pslverr without pready");
    a_div_clamp: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && state.pready && pwrite && !state.pslverr && (paddr == addr_pulse_div)
        && (pwdata[15:0] < 16'(pulse_min_half)) |=> state.pulse_div == 16'(pulse_min_half))
        else $error("pulse divider not clamped");
    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && state.pready && pwrite && !state.pslverr && (paddr == addr_mux_mode)
        |=> state.mux_mode == 16'($past(pwdata)))
        else $error("mode write lost");

endmodule // output_terminal_function_select

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb;
    import terminal_select_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, last_half, high_len;
    logic err;
    drive_status_s st;
    terminals_s terminals;
    logic [15:0] sel [num_outputs];
    int fail_count, checks_done, seed, cycles;

    output_terminal_function_select #(.seq_pulse_len(20)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_in(st),
        .terminals(terminals));
    terminal_load load_u (.pclk(pclk), .presetn(presetn), .terminals(terminals),
        .last_half(last_half), .high_len(high_len));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // hang guard, well above the planned run length
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            fail_count = fail_count + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the hang guard ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic want(input logic [15:0] c, input drive_status_s s);
        case (c)
            16'h0001: return s.ready && !s.fault_stop;
            16'h0002: return s.running;
            16'h0003: return s.fault_stop;
            16'h0004: return s.fault_coast && !s.undervoltage;
            16'h0005: return s.freq_limited;
            16'h0006: return s.torque_limited;
            16'h0007: return s.upper_reached;
            16'h0008: return s.lower_reached && s.running;
            16'h0009: return s.lower_reached || !s.running;
            16'h000a: return s.reverse && s.running;
            16'h000b: return s.zero_freq && s.running;
            16'h000c: return s.zero_freq || !s.running;
            16'h000d: return s.set_count_reached;
            16'h000e: return s.designated_count_reached;
            16'h000f: return s.length_reached;
            16'h0011: return s.freq_level_detect_first;
            16'h0012: return s.freq_level_detect_second;
            16'h0013: return s.freq_reached;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        logic [8:0] exp, got;
        fail_count = 0;
        checks_done = 0;
        cycles = 0;
        seed = 33469;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        st = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, addr_mux_mode, 32'h0);
        chk("mux mode reset", 32'h1, rd);
        for (int i = 0; i < num_outputs; i++) begin
            apb(1'b0, addr_func_base + 12'(4 * i), 32'h0);
            chk("selector reset", {16'h0, func_reset[i]}, rd);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, 12'h006, 32'h5);
        chk("unaligned error", 32'h1, {31'h0, err});
        apb(1'b0, addr_pulse_div, 32'h0);
        chk("pulse div reset", {16'h0, pulse_div_reset}, rd);
        apb(1'b1, addr_pulse_div, 32'h5);
        apb(1'b0, addr_pulse_div, 32'h0);
        chk("pulse div clamp", 32'(pulse_min_half), rd);
        $display("test registers done");
        // random selectors and status; index 1 sweeps codes 0 to 21 in turn, except 16
        for (int k = 0; k < 44; k++) begin
            for (int i = 0; i < num_outputs; i++) begin
                sel[i] = (i == 1) ? 16'(k % 22) : 16'($unsigned($random(seed)) % 22);
                if (sel[i] == 16'h0010 || k == 43)
                    sel[i] = (k == 43) ? 16'hffff : 16'h0000;
                apb(1'b1, addr_func_base + 12'(4 * i), {16'h0, sel[i]});
            end
            st <= drive_status_s'(18'($random(seed))) & ~18'h00008;
            repeat (8) @(posedge pclk);
            for (int i = 0; i < num_outputs; i++)
                exp[i] = want(sel[i], st);
            got = {terminals.extension_relay_contacts, terminals.extension_outputs,
                   terminals.base_collector_output,
                   terminals.board_relay_contacts, terminals.multiplexed_switch_output};
            chk("terminals", {23'h0, exp}, {23'h0, got});
        end
        apb(1'b0, addr_status, 32'h0);
        chk("status read", 32'(st), rd);
        $display("test selectors done");
        apb(1'b1, addr_func_base, {16'h0, fn_ready});
        st <= '{ready: 1'b1, default: 1'b0};
        apb(1'b1, addr_mux_mode, {16'h0, mux_mode_pulse});
        repeat (3500) @(posedge pclk);
        chk("pulse half period", {16'h0, pulse_div_reset}, last_half);
        chk("switch off in pulse mode", 32'h0, {31'h0, terminals.multiplexed_switch_output});
        apb(1'b1, addr_mux_mode, {16'h0, mux_mode_switch});
        repeat (8) @(posedge pclk);
        chk("switch back", 32'h1, {31'h0, terminals.multiplexed_switch_output});
        $display("test pulse mode done");
        apb(1'b1, addr_func_base + 12'h008, {16'h0, fn_sequencer_done});
        st.sequencer_cycle_done <= 1'b1;
        repeat (3) @(posedge pclk);
        st.sequencer_cycle_done <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("cycle done pulse width", 32'd20, high_len);
        $display("test sequencer pulse done");
        final_report();
    end
endmodule // tb

`default_nettype wire

// ---- terminal_load.sv ----
`timescale 1ns/10ps
`default_nettype none

// ***************************************************
// load model: indicator lamps on the output terminals
// ***************************************************
module terminal_load
    import terminal_select_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire terminal_select_pkg::terminals_s terminals,
    output logic [31:0] last_half,
    output logic [31:0] high_len
);
    logic prev_pulse;
    logic prev_base;
    logic [31:0] half_cnt;
    logic [31:0] high_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_pulse <= 1'b0;
            half_cnt <= 32'h0;
            last_half <= 32'h0;
        end else begin
            prev_pulse <= terminals.multiplexed_pulse_output;
            if (terminals.multiplexed_pulse_output != prev_pulse) begin
                last_half <= half_cnt;
                half_cnt <= 32'h1;
            end else begin
                half_cnt <= half_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_base <= 1'b0;
            high_cnt <= 32'h0;
            high_len <= 32'h0;
        end else begin
            prev_base <= terminals.base_collector_output;
            if (terminals.base_collector_output) begin
                high_cnt <= high_cnt + 32'h1;
            end else if (prev_base) begin
                high_len <= high_cnt;
                high_cnt <= 32'h0;
            end
        end
    end
endmodule // terminal_load

`default_nettype wire

// ---- terminal_select_pkg.sv ----
package terminal_select_pkg;

    localparam int num_outputs = 9;
    localparam int sel_width = 16;

    // ***************************************************
    // register word addresses
    // ***************************************************
    localparam logic [11:0] addr_mux_mode = 12'h000;
    localparam logic [11:0] addr_func_base = 12'h004;
    localparam logic [11:0] addr_status = 12'h028;
    localparam logic [11:0] addr_terminals = 12'h02c;
    localparam logic [11:0] addr_pulse_div = 12'h030;

    localparam logic [15:0] mux_mode_reset = 16'h0001;
    localparam logic [15:0] mux_mode_pulse = 16'h0000;
    localparam logic [15:0] mux_mode_switch = 16'h0001;

    // ***************************************************
    // selector codes
    // ***************************************************
    localparam logic [15:0] fn_none = 16'h0000;
    localparam logic [15:0] fn_ready = 16'h0001;
    localparam logic [15:0] fn_running = 16'h0002;
    localparam logic [15:0] fn_fault_stop = 16'h0003;
    localparam logic [15:0] fn_fault_coast = 16'h0004;
    localparam logic [15:0] fn_freq_limited = 16'h0005;
    localparam logic [15:0] fn_torque_limited = 16'h0006;
    localparam logic [15:0] fn_upper_reached = 16'h0007;
    localparam logic [15:0] fn_lower_run = 16'h0008;
    localparam logic [15:0] fn_lower_stop = 16'h0009;
    localparam logic [15:0] fn_reverse = 16'h000a;
    localparam logic [15:0] fn_zero_run = 16'h000b;
    localparam logic [15:0] fn_zero_stop = 16'h000c;
    localparam logic [15:0] fn_set_count = 16'h000d;
    localparam logic [15:0] fn_designated_count = 16'h000e;
    localparam logic [15:0] fn_length = 16'h000f;
    localparam logic [15:0] fn_sequencer_done = 16'h0010;
    localparam logic [15:0] fn_fdt_first = 16'h0011;
    localparam logic [15:0] fn_fdt_second = 16'h0012;
    localparam logic [15:0] fn_freq_reached = 16'h0013;

    // reset selectors, index 0..8: switch, relay, base collector, ext two..six, ext relay
    localparam logic [15:0] func_reset [num_outputs] = '{
        16'h0000, 16'h0002, 16'h0001, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // ***************************************************
    // timing
    // ***************************************************
    localparam int clk_mhz = 100;
    localparam int seq_pulse_ms = 250;
    localparam int seq_pulse_cycles = seq_pulse_ms * 1000 * clk_mhz;
    localparam int pulse_max_khz = 50;
    // fastest half period for a 50 kHz pulse train
    localparam int pulse_min_half = (clk_mhz * 1000) / (pulse_max_khz * 2);
    localparam logic [15:0] pulse_div_reset = 16'h03e8;

    typedef struct packed {
        logic ready;
        logic running;
        logic fault_stop;
        logic fault_coast;
        logic undervoltage;
        logic freq_limited;
        logic torque_limited;
        logic upper_reached;
        logic lower_reached;
        logic reverse;
        logic zero_freq;
        logic set_count_reached;
        logic designated_count_reached;
        logic length_reached;
        logic sequencer_cycle_done;
        logic freq_level_detect_first;
        logic freq_level_detect_second;
        logic freq_reached;
    } drive_status_s;

    typedef struct packed {
        logic multiplexed_pulse_output;
        logic multiplexed_switch_output;
        logic board_relay_contacts;
        logic base_collector_output;
        logic [4:0] extension_outputs;
        logic extension_relay_contacts;
    } terminals_s;

endpackage : terminal_select_pkg
